// *** core/swt_pkg.sv ***
// shared constants and carriers for the switch input tri-state / wetting registers
package swt_pkg;

    // register bus geometry
    localparam int ADDR_W = 7;                  // register address width
    localparam int DATA_W = 24;                 // register data width
    localparam int SP_N   = 8;                  // programmable inputs
    localparam int SG_N   = 14;                 // ground-only inputs
    localparam int IN_N   = SP_N + SG_N;        // all sensed inputs
    localparam int LVL_W  = 3;                  // level code width per input

    // register addresses
    localparam logic [ADDR_W-1:0] ADDR_SP_HIGH_Z = 7'h02;
    localparam logic [ADDR_W-1:0] ADDR_SG_HIGH_Z = 7'h03;
    localparam logic [ADDR_W-1:0] ADDR_SP_LEVEL  = 7'h04;

    // field positions in the read word
    localparam int FAULT_BIT = 23;              // fault status in programmable tri-state reads
    localparam int IRQ_BIT   = 22;              // interrupt flag in programmable tri-state reads

    // power-on defaults
    localparam logic [SP_N-1:0]     SP_HIGH_Z_RST = 8'hff;
    localparam logic [SG_N-1:0]     SG_HIGH_Z_RST = 14'h3fff;
    localparam logic [LVL_W-1:0]    LEVEL_RST     = 3'h6;        // 16 mA
    localparam logic [DATA_W-1:0]   SP_LEVEL_RST  = {SP_N{LEVEL_RST}};

    // wetting current per level code, in tenths of a milliamp
    localparam logic [7:0][7:0] LEVEL_DMA = {
        8'hc8, 8'ha0, 8'h8c, 8'h78, 8'h64, 8'h50, 8'h3c, 8'h14
    };

    // timing of the low-power poll
    localparam int CLK_HZ         = 50_000_000;   // sys_clk rate
    localparam int ACTIVE_POLL_NS = 55_000;       // sources on / sensing window
    localparam int ACTIVE_POLL_CYC = (ACTIVE_POLL_NS / 1000) * (CLK_HZ / 1_000_000);
    localparam int POLL_PERIOD_US = 64_000;       // sleep time between polls
    localparam int POLL_PERIOD_CYC = POLL_PERIOD_US * (CLK_HZ / 1_000_000);
    localparam int CNT_W          = 32;

    // register access request from the serial front end
    typedef struct packed {
        logic              wr;      // one-cycle write strobe
        logic              rd;      // one-cycle read strobe
        logic [ADDR_W-1:0] addr;    // register address
        logic [DATA_W-1:0] wdata;   // write data
    } swt_req_s;

    // poll sequencer states
    typedef enum logic [0:0] {
        POLL_SLEEP,
        POLL_ACTIVE
    } swt_poll_e;

endpackage

// *** core/swt_regs.sv ***
`timescale 1ns/1ns
`default_nettype none

module swt_regs #(
    parameter int POLL_PERIOD = swt_pkg::POLL_PERIOD_CYC  // sleep cycles between polls
) (
    // clock and reset
    input  wire logic                                      sys_clk,
    input  wire logic                                      rst_n,
    // register access from the serial front end
    input  wire swt_pkg::swt_req_s                         req,
    output var  logic [swt_pkg::DATA_W-1:0]                rdata,
    output var  logic                                      rvalid,
    // status merged into programmable tri-state reads
    input  wire logic                                      fault_status,
    input  wire logic                                      interrupt_pending_flag,
    // mode and polarity from the device configuration
    input  wire logic                                      low_power_state,
    input  wire logic [swt_pkg::SP_N-1:0]                  sp_to_battery,
    // raw comparator outputs, asynchronous
    input  wire logic [swt_pkg::IN_N-1:0]                  cmp_raw,
    // current source controls
    output var  logic [swt_pkg::SP_N-1:0]                  sp_source_en,
    output var  logic [swt_pkg::SG_N-1:0]                  sg_source_en,
    output var  logic [swt_pkg::DATA_W-1:0]                sp_level,
    output var  logic [swt_pkg::SP_N-1:0][7:0]             sp_current_dma,
    // sensed switch state and low power events
    output var  logic [swt_pkg::IN_N-1:0]                  switch_closed,
    output var  logic                                      poll_active,
    output var  logic                                      wake_event
);
    import swt_pkg::*;

    // overview of this block
    // three host registers sit behind the serial front end
    // the front end hands over one decoded strobe per access
    // writes take effect at the edge that carries the strobe
    // reads are answered one cycle later with rvalid
    // tri-state bits gate the wetting current sources
    // level fields pick a current from a fixed table
    // comparators are sensed whether or not sources are on
    // low power mode runs a sleep and sense poll cycle
    // a change found at the end of a poll raises wake_event
    // hazards kept in mind
    // the comparator pins are not on this clock
    // so nothing reads them before two flip-flops
    // source enables lag the registers by one cycle
    // the host must allow that cycle before sensing

    // register storage
    logic [SP_N-1:0]    sp_high_z;      // programmable input tri-state bits
    logic [SG_N-1:0]    sg_high_z;      // ground input tri-state bits

    // comparator synchroniser
    logic [IN_N-1:0]    cmp_meta;       // first stage, read only by cmp_sync
    logic [IN_N-1:0]    cmp_sync;       // second stage, safe to use

    // poll sequencer
    swt_poll_e          poll_state;
    swt_poll_e          next_poll_state;
    logic [CNT_W-1:0]   poll_cnt;
    logic [CNT_W-1:0]   next_poll_cnt;
    logic [IN_N-1:0]    ref_closed;     // state seen at low power entry or at the previous decision
    logic               lpm_q;          // low power state one cycle ago

    // address decode
    wire hit_sp_z   = (req.addr == ADDR_SP_HIGH_Z);
    wire hit_sg_z   = (req.addr == ADDR_SG_HIGH_Z);
    wire hit_lvl    = (req.addr == ADDR_SP_LEVEL);
    wire wr_sp_z    = req.wr & hit_sp_z;
    wire wr_sg_z    = req.wr & hit_sg_z;
    wire wr_lvl     = req.wr & hit_lvl;

    // read words, unused bits tied to zero
    wire [DATA_W-1:0] rd_sp_z = {fault_status, interrupt_pending_flag,
                                 {(DATA_W-SP_N-2){1'b0}}, sp_high_z};
    wire [DATA_W-1:0] rd_sg_z = {{(DATA_W-SG_N){1'b0}}, sg_high_z};
    wire [DATA_W-1:0] rd_word = hit_sp_z ? rd_sp_z :
                                hit_sg_z ? rd_sg_z :
                                hit_lvl  ? sp_level :
                                {DATA_W{1'b0}};

    // switch closure: battery switch pulls high, ground switch pulls low
    wire [SP_N-1:0] sp_closed = ~(cmp_sync[SP_N-1:0] ^ sp_to_battery);
    wire [SG_N-1:0] sg_closed = ~cmp_sync[IN_N-1:SP_N];
    wire [IN_N-1:0] now_closed = {sg_closed, sp_closed};

    // low power entry and end of the active window
    wire lpm_enter   = low_power_state & ~lpm_q;
    wire active_last = (poll_state == POLL_ACTIVE) &&
                       (poll_cnt == CNT_W'(ACTIVE_POLL_CYC - 1));

    // source gating notes
    // a set tri-state bit always wins over the level code
    // the level field stays stored and readable meanwhile
    // clearing the bit brings the source back next cycle
    // in normal mode the gate stays open all the time
    // in low power the gate opens only in the sense window
    // tri-stated inputs stay dark in the window as well
    // their comparators are still sampled there
    // the source flops reset to off, not to the table
    // this keeps the pins quiet while reset is held
    // ground inputs share the same gate as programmable ones
    // no per-input timing is applied here
    // pulsed wetting belongs to another block
    // continuous wetting control is also outside
    // only on or off per input, plus a current value per programmable input, leave this block

    // sources: on where not tri-stated; in low power only during a poll
    wire src_gate = ~low_power_state | (poll_state == POLL_ACTIVE);
    wire [SP_N-1:0] next_sp_src = ~sp_high_z & {SP_N{src_gate}};
    wire [SG_N-1:0] next_sg_src = ~sg_high_z & {SG_N{src_gate}};

    // tri-state registers, written straight from the bus
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sp_high_z <= SP_HIGH_Z_RST;
            sg_high_z <= SG_HIGH_Z_RST;
        end else begin
            if (wr_sp_z) begin
                sp_high_z <= req.wdata[SP_N-1:0];
            end
            if (wr_sg_z) begin
                sg_high_z <= req.wdata[SG_N-1:0];
            end
        end
    end

    // level register, all 24 bits live
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sp_level <= SP_LEVEL_RST;
        end else if (wr_lvl) begin
            sp_level <= req.wdata;
        end
    end

    // per input level field to current lookup
    generate
        for (genvar n = 0; n < SP_N; n++) begin : g_level
            // input n takes bits 3n+2 down to 3n
            wire [LVL_W-1:0] code = sp_level[n*LVL_W +: LVL_W];
            always_ff @(posedge sys_clk) begin
                if (!rst_n) begin
                    sp_current_dma[n] <= LEVEL_DMA[LEVEL_RST];
                end else begin
                    sp_current_dma[n] <= LEVEL_DMA[code];
                end
            end
        end
    endgenerate

    // read path notes
    // the read word is chosen from the address alone
    // a read and a write in one cycle return the old value
    // status bits are sampled with the read strobe
    // they are not stored anywhere else in this block
    // unmapped addresses return an all zero word
    // unused bits inside mapped words read zero too
    // written values in unused bits are simply dropped
    // rdata holds until the next read strobe arrives
    // rvalid is a single cycle pulse per read
    // back to back reads give back to back pulses
    // nothing stalls, so no ready signal exists
    // the front end must take rdata with rvalid
    // or at any later cycle before the next read
    // rdata clears to zero during reset
    // rvalid stays low during reset

    // read answer, one cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rdata  <= {DATA_W{1'b0}};
            rvalid <= 1'b0;
        end else begin
            rvalid <= req.rd;
            if (req.rd) begin
                rdata <= rd_word;
            end
        end
    end

    // comparator synchroniser, sensed regardless of tri-state
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cmp_meta <= {IN_N{1'b0}};
            cmp_sync <= {IN_N{1'b0}};
        end else begin
            cmp_meta <= cmp_raw;
            cmp_sync <= cmp_meta;
        end
    end

    // reported switch state and source drives
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            switch_closed <= {IN_N{1'b0}};
            sp_source_en  <= {SP_N{1'b0}};
            sg_source_en  <= {SG_N{1'b0}};
        end else begin
            switch_closed <= now_closed;
            sp_source_en  <= next_sp_src;
            sg_source_en  <= next_sg_src;
        end
    end

    // poll sequencer notes
    // the sequencer idles in sleep while in normal mode
    // its counter is held at zero there
    // entering low power starts the sleep count
    // after the period the window opens
    // the window lasts a fixed number of cycles
    // on its last cycle the change decision is made
    // then the sequencer goes back to sleep
    // leaving low power aborts any window at once
    // an aborted window gives no wake event
    // the counter is wide enough for the longest period
    // the period is a parameter so tests can shorten it
    // the window length stays fixed in the package
    // poll_active mirrors the next state, so it is a flop
    // it rises on the first window cycle

    // poll sequencer: sleep for the period, then sense for the window
    always_comb begin
        next_poll_state = poll_state;
        next_poll_cnt   = poll_cnt + CNT_W'(1);
        case (poll_state)
            POLL_SLEEP: begin
                // leave sleep when the period has run out
                if (!low_power_state) begin
                    next_poll_cnt = {CNT_W{1'b0}};
                end else if (poll_cnt >= CNT_W'(POLL_PERIOD - 1)) begin
                    next_poll_state = POLL_ACTIVE;
                    next_poll_cnt   = {CNT_W{1'b0}};
                end
            end
            POLL_ACTIVE: begin
                // window over or low power left
                if (!low_power_state || active_last) begin
                    next_poll_state = POLL_SLEEP;
                    next_poll_cnt   = {CNT_W{1'b0}};
                end
            end
            default: begin
                next_poll_state = POLL_SLEEP;
                next_poll_cnt   = {CNT_W{1'b0}};
            end
        endcase
    end

    // sequencer state
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            poll_state <= POLL_SLEEP;
            poll_cnt   <= {CNT_W{1'b0}};
            lpm_q      <= 1'b0;
        end else begin
            poll_state <= next_poll_state;
            poll_cnt   <= next_poll_cnt;
            lpm_q      <= low_power_state;
        end
    end

    // change decision notes
    // the reference is the switch state on low power entry
    // each window end compares against that reference
    // then the reference takes the state just seen
    // so each wake reports a change since the last poll
    // all inputs are compared together as one word
    // tri-stated inputs take part in the compare
    // wake_event is a one cycle pulse
    // it rises with the first sleep cycle after a window
    // no wake is given in the middle of a window
    // no wake is given in normal mode
    // wake handling and mode exit lie outside this block
    // the host clears low power after the wake
    // the reference is refreshed on the next entry
    // reset clears the reference and the pulse

    // change decision at the window end, reference taken on entry
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ref_closed  <= {IN_N{1'b0}};
            wake_event  <= 1'b0;
            poll_active <= 1'b0;
        end else begin
            poll_active <= (next_poll_state == POLL_ACTIVE);
            wake_event  <= 1'b0;
            if (lpm_enter) begin
                ref_closed <= now_closed;
            end else if (active_last && low_power_state) begin
                ref_closed <= now_closed;
                wake_event <= (now_closed != ref_closed);
            end
        end
    end

endmodule

`default_nettype wire

// *** sim/swt_props.sv ***
`timescale 1ns/1ns
`default_nettype none
// port-level checks of the register block
module swt_props import swt_pkg::*; #(parameter int POLL_PERIOD = 20) (
    // clock, reset, request
    input wire logic                 sys_clk,
    input wire logic                 rst_n,
    input wire swt_req_s             req,
    input wire logic [DATA_W-1:0]    rdata,
    input wire logic                 rvalid,
    // status, mode, comparators
    input wire logic                 fault_status,
    input wire logic                 interrupt_pending_flag,
    input wire logic                 low_power_state,
    input wire logic [SP_N-1:0]      sp_to_battery,
    input wire logic [IN_N-1:0]      cmp_raw,
    // source controls and sensed state
    input wire logic [SP_N-1:0]      sp_source_en,
    input wire logic [SG_N-1:0]      sg_source_en,
    input wire logic [DATA_W-1:0]    sp_level,
    input wire logic [SP_N-1:0][7:0] sp_current_dma,
    input wire logic [IN_N-1:0]      switch_closed,
    input wire logic                 poll_active,
    input wire logic                 wake_event
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // two sleeping cycles of low power
    sequence s_asleep;
        (low_power_state && !poll_active) [*2];
    endsequence
    // a read of one address
    sequence s_rd(a);
        req.rd && req.addr == a;
    endsequence
    a_read_answer: assert property (req.rd |=> rvalid)
        else $error("read not answered");
    a_no_stray: assert property (!req.rd |=> !rvalid)
        else $error("answer without read");
    a_status_word: assert property (s_rd(ADDR_SP_HIGH_Z) |=> rdata[21:8] == '0 &&
        rdata[23:22] == $past({fault_status, interrupt_pending_flag})) else $error("bad status word");
    a_ground_unused: assert property (s_rd(ADDR_SG_HIGH_Z) |=> rdata[23:14] == '0)
        else $error("ground word upper bits set");
    a_level_read: assert property (s_rd(ADDR_SP_LEVEL) |=> rdata == $past(sp_level))
        else $error("level word differs");
    a_unmapped_zero: assert property (req.rd && !(req.addr inside {[2:4]}) |=> rdata == '0)
        else $error("unmapped read not zero");
    a_level_table: assert property (1 |=> sp_current_dma[0] == LEVEL_DMA[$past(sp_level[2:0])]
        && sp_current_dma[7] == LEVEL_DMA[$past(sp_level[23:21])]) else $error("bad current");
    a_tri_src_off: assert property (req.wr && req.addr == ADDR_SP_HIGH_Z |-> ##2
        (sp_source_en & $past(req.wdata[SP_N-1:0], 2)) == '0) else $error("source on");
    a_sleep_off: assert property (s_asleep |-> sp_source_en == '0 && sg_source_en == '0)
        else $error("source on while asleep");
    a_wake_end: assert property (wake_event |-> $past(poll_active) && !poll_active)
        else $error("wake outside window end");
    a_switch_sense: assert property ($past(rst_n, 4) ##0 ($stable({cmp_raw, sp_to_battery}))[*4]
        |-> switch_closed == {~cmp_raw[IN_N-1:SP_N], cmp_raw[SP_N-1:0] ~^ sp_to_battery})
        else $error("sensed state wrong");
endmodule
`default_nettype wire

// *** sim/swt_host.sv ***
`timescale 1ns/1ns
`default_nettype none
// host side: register strobes launched off the falling edge
module swt_host import swt_pkg::*; (
    input  wire logic              sys_clk,
    output var  swt_req_s          req,
    input  wire logic [DATA_W-1:0] rdata,
    input  wire logic              rvalid
);
    initial req = '0;
    // one write, strobe dropped after the taking edge
    task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(negedge sys_clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge sys_clk);
        req.wr <= 1'b0;
    endtask
    // one read, answer taken once the strobe edge has passed
    task automatic reg_rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
                          output logic ok);
        @(negedge sys_clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: '0};
        @(negedge sys_clk);
        req.rd <= 1'b0;
        ok = rvalid;
        d = rdata;
    endtask
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import swt_pkg::*;
    logic sys_clk, rst_n, rvalid, fault_status, interrupt_pending_flag;
    logic low_power_state, poll_active, wake_event;
    swt_req_s req;
    logic [DATA_W-1:0] rdata, sp_level;
    logic [SP_N-1:0] sp_to_battery, sp_source_en;
    logic [SG_N-1:0] sg_source_en;
    logic [IN_N-1:0] cmp_raw, switch_closed;
    logic [SP_N-1:0][7:0] sp_current_dma;
    int err_total, total_checks, cyc;
    swt_regs #(.POLL_PERIOD(20)) swt_regs_inst (.*);
    swt_host swt_host_inst (.*);
    // 50 MHz clock
    initial begin
        sys_clk = 0;
        forever #10 sys_clk = ~sys_clk;
    end
    task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic rd_chk(input string n, input logic [6:0] a, input logic [23:0] e);
        logic [23:0] d;
        logic ok;
        swt_host_inst.reg_rd(a, d, ok);
        chk(n, {23'h0, 1'b1}, {23'h0, ok});
        chk(n, e, d);
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // hang guard
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            give_verdict();
        end
    end
    task automatic t_tri;
        rd_chk("sp tri", ADDR_SP_HIGH_Z, 24'h80_00ff);
        rd_chk("sg tri", ADDR_SG_HIGH_Z, 24'h00_3fff);
        rd_chk("level", ADDR_SP_LEVEL, 24'hdb_6db6);
        chk("src", 24'h0, {2'b0, sg_source_en, sp_source_en});
        fault_status = 0;
        interrupt_pending_flag = 1;
        swt_host_inst.reg_wr(ADDR_SP_HIGH_Z, 24'hff_ff5a);
        swt_host_inst.reg_wr(ADDR_SG_HIGH_Z, 24'hff_c0f0);
        rd_chk("sp tri w", ADDR_SP_HIGH_Z, 24'h40_005a);
        rd_chk("sg tri w", ADDR_SG_HIGH_Z, 24'h00_00f0);
        chk("src w", 24'h3f_0fa5, {2'b0, sg_source_en, sp_source_en});
        rd_chk("unmapped", 7'h05, 24'h0);
    endtask
    task automatic t_level;
        int tbl[8] = '{20, 60, 80, 100, 120, 140, 160, 200};
        for (int c = 0; c < 8; c++) begin
            swt_host_inst.reg_wr(ADDR_SP_LEVEL, {8{3'(c)}});
            @(negedge sys_clk);
            for (int k = 0; k < 8; k++) chk("current", 24'(tbl[c]), {16'h0, sp_current_dma[k]});
        end
        swt_host_inst.reg_wr(ADDR_SP_LEVEL, 24'hfa_c688);
        rd_chk("level n", ADDR_SP_LEVEL, 24'hfa_c688);
        chk("cur n", 24'hc8_6414, {sp_current_dma[7], sp_current_dma[3], sp_current_dma[0]});
    endtask
    task automatic t_switch;
        sp_to_battery = 8'hf0;
        cmp_raw = {14'h2aaa, 8'h3c};
        repeat (5) @(negedge sys_clk);
        chk("closed", 24'h15_5533, {2'b0, switch_closed});
        sp_to_battery = 8'h0f;
        repeat (5) @(negedge sys_clk);
        chk("closed", 24'h15_55cc, {2'b0, switch_closed});
    endtask
    task automatic t_lpm;
        int n;
        int early;
        swt_host_inst.reg_wr(ADDR_SP_HIGH_Z, 24'h00_000f);
        low_power_state = 1;
        for (n = 0; poll_active !== 1 && n < 200; n++) @(negedge sys_clk);
        chk("poll", 24'h1, {23'h0, poll_active});
        repeat (2) @(negedge sys_clk);
        chk("poll src", 24'h3f_0ff0, {2'b0, sg_source_en, sp_source_en});
        cmp_raw[0] = ~cmp_raw[0];
        early = 0;
        for (n = 0; poll_active !== 0 && n < 4000; n++) begin
            @(negedge sys_clk);
            if (wake_event === 1 && poll_active === 1) early++;
        end
        chk("wake", 24'h1, {23'h0, wake_event});
        chk("early wake", 24'h0, 24'(early));
        low_power_state = 0;
    endtask
    initial begin
        rst_n = 0;
        fault_status = 1;
        interrupt_pending_flag = 0;
        low_power_state = 0;
        sp_to_battery = 8'hff;
        cmp_raw = '0;
        repeat (12) @(negedge sys_clk);
        rst_n = 1;
        t_tri();
        t_level();
        t_switch();
        t_lpm();
        give_verdict();
    end
endmodule
bind swt_regs swt_props #(.POLL_PERIOD(POLL_PERIOD)) swt_props_inst (.*);
`default_nettype wire
